/* File: flow_port_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// port checker
// ----------------
module flow_port_checker (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [8:0] rom_data,
    input wire logic [15:0] d_port,
    input wire logic [7:0] s_port_out,
    input wire logic [7:0] s_port_oe_n,
    input wire logic p_port
);
    // one domain, so clock and reset once
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // words that may never touch a port
    wire quiet = rom_data inside {9'h000, 9'h00B, 9'h00A, 9'h0B8, 9'h0F8, 9'h001, 9'h004, 9'h008};
    // read address phase, the only thing that may move hrdata
    wire rd_taken = hsel && htrans[1] && hready && !hwrite;
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_oe_mirror: assert property (s_port_oe_n == ~s_port_out)
        else $error("s pin enable differs from latch");
    a_rd_hold: assert property (!$past(rd_taken) |-> $stable(hrdata))
        else $error("read data moved without a read");
    a_quiet_ops: assert property ($past(quiet) |-> $stable(d_port) && $stable(s_port_out) && $stable(p_port))
        else $error("port moved after a quiet word");
    a_d_cause: assert property ($changed(d_port) |-> $past(rom_data) inside {9'h00F, 9'h00E, 9'h007})
        else $error("d port moved without cause");
    a_d_onebit: assert property ($changed(d_port) && d_port != 16'h0 |-> $onehot(d_port ^ $past(d_port)))
        else $error("d port moved more than one bit");
    a_d_set: assert property ($past(rom_data) == 9'h00F |-> ($past(d_port) & ~d_port) == 16'h0)
        else $error("bit set cleared a bit");
    a_d_reset: assert property ($past(rom_data) == 9'h00E |-> (d_port & ~$past(d_port)) == 16'h0)
        else $error("bit reset set a bit");
    a_s_cause: assert property ($changed(s_port_out) || $changed(p_port)
        |-> $past(rom_data) inside {9'h0B3, 9'h0B2, 9'h0F2, 9'h007})
        else $error("s or p moved without cause");
    a_clr_all: assert property ($changed(d_port) && $changed(s_port_out) |-> d_port == 16'h0 && s_port_out == 8'h0 && !p_port)
        else $error("joint port change was not a clear");
    c_set: cover property ($rose(|d_port));
    c_out: cover property ($changed(s_port_out));
    c_clr: cover property ($fell(p_port));
endmodule // flow_port_checker
bind flow_port_core flow_port_checker u_chk (.core_clk, .reset_n, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .hrdata, .rom_data, .d_port, .s_port_out, .s_port_oe_n, .p_port);
`default_nettype wire

/* File: flow_port_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flow_port_defines.svh"

module flow_port_core #(
    parameter logic [7:0] CYC_DIV = `CYC_DIV_DEF,
    parameter logic [10:0] IRQ_VEC = `RST_IRQ_VEC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output flow_port_pkg::prog_counter_t rom_addr,
    input wire logic [8:0] rom_data,
    output logic [15:0] d_port,
    output logic [7:0] s_port_out,
    output logic [7:0] s_port_oe_n,
    input wire logic [3:0] s_port_in,
    output logic p_port,
    input wire logic [3:0] k_port,
    input wire logic [1:0] t_port,
    input wire logic irq_in
);
    import flow_port_pkg::*;

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // next sequential address, wraps inside the page
    function automatic prog_counter_t pc_next(input prog_counter_t pc);
        pc_next = {pc.page_field, pc.in_page_address + 7'h01};
    endfunction

    // 8-segment pattern, bit 7 is the decimal point (kept dark)
    function automatic logic [7:0] seg_decode(input logic [3:0] v);
        unique case (v)
            4'h0: seg_decode = 8'h3F;
            4'h1: seg_decode = 8'h06;
            4'h2: seg_decode = 8'h5B;
            4'h3: seg_decode = 8'h4F;
            4'h4: seg_decode = 8'h66;
            4'h5: seg_decode = 8'h6D;
            4'h6: seg_decode = 8'h7D;
            4'h7: seg_decode = 8'h07;
            4'h8: seg_decode = 8'h7F;
            4'h9: seg_decode = 8'h6F;
            4'hA: seg_decode = 8'h77;
            4'hB: seg_decode = 8'h7C;
            4'hC: seg_decode = 8'h39;
            4'hD: seg_decode = 8'h5E;
            4'hE: seg_decode = 8'h79;
            4'hF: seg_decode = 8'h71;
        endcase
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic run_r; // software run switch
    logic [7:0] div_r; // machine cycle divider
    seq_state_t state_r; // sequencer phase
    logic [1:0] wait_r; // extra machine cycles left
    prog_counter_t pc_r; // program counter
    prog_counter_t stack_entry_first_r; // top of stack
    prog_counter_t stack_entry_second_r; // second stack level
    logic sub_mode_flag_r; // subroutine mode
    logic sub_mode_save_r; // mode held at interrupt entry
    logic irq_enable_flag_r; // interrupt enable
    logic irq_pend_r; // latched interrupt request
    logic irq_prev_r; // edge detect history
    logic skip_r; // next word is skipped
    logic skip2_r; // second word of a skipped long op
    logic call2_r; // second word belongs to a call
    logic [3:0] long_page_r; // page from first long word
    acc_regs_t acc_r; // accumulator, B, carry
    ram_pointer_t ram_pointer_r; // data pointer
    logic [7:0] stage_r; // output staging register
    logic c_r; // one-bit output carry register
    out_ports_t out_r; // port latches
    logic [10:0] pin_meta_r; // first sync stage, read only by next
    logic [10:0] pin_sync_r; // second sync stage
    logic wr_pend_r; // bus write in data phase
    logic [7:0] wr_addr_r; // address of that write

    // ----------------------------------------
    // synchronised pins
    // ----------------------------------------
    wire [3:0] s_low_in = pin_sync_r[3:0];
    wire [3:0] k_in = pin_sync_r[7:4];
    wire [1:0] t_in = pin_sync_r[9:8];
    wire irq_lvl = pin_sync_r[10];

    // two flops on every asynchronous input
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta_r <= 11'h000;
            pin_sync_r <= 11'h000;
        end
        else
        begin
            pin_meta_r <= {irq_in, t_port, k_port, s_port_in};
            pin_sync_r <= pin_meta_r;
        end
    end

    // ----------------------------------------
    // machine cycle enable
    // ----------------------------------------
    wire tick = (div_r == 8'h00);

    // free-running divider, one pulse per machine cycle
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            div_r <= 8'h00;
        else if (tick)
            div_r <= CYC_DIV - 8'h01;
        else
            div_r <= div_r - 8'h01;
    end

    // ----------------------------------------
    // register bus slave
    // ----------------------------------------
    wire bus_req = hsel & htrans[1] & hready;
    wire wr_ctrl = wr_pend_r && (wr_addr_r == `OFS_CTRL);
    wire wr_acc = wr_pend_r && (wr_addr_r == `OFS_ACC);
    wire wr_ptr = wr_pend_r && (wr_addr_r == `OFS_PTR);
    wire [7:0] rd_addr = haddr[7:0];
    wire [31:0] stat_word = {17'h00000, state_r != ST_EXEC, sub_mode_save_r, irq_enable_flag_r,
                             sub_mode_flag_r, pc_r};
    // unmapped offsets read zero, writes to them are dropped
    wire [31:0] rd_mux = (rd_addr == `OFS_CTRL) ? {31'h00000000, run_r} :
                         (rd_addr == `OFS_ACC) ? {23'h000000, acc_r} :
                         (rd_addr == `OFS_PTR) ? {25'h0000000, ram_pointer_r} :
                         (rd_addr == `OFS_STAT) ? stat_word :
                         (rd_addr == `OFS_PORT) ? {7'h00, out_r} : 32'h00000000;

    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay

    // address phase capture; read data launched for the data phase
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata <= 32'h00000000;
        end
        else
        begin
            wr_pend_r <= bus_req & hwrite;
            wr_addr_r <= rd_addr;
            if (bus_req & !hwrite)
                hrdata <= rd_mux;
        end
    end

    // run switch; stopping freezes the sequencer between cycles
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
            run_r <= `RST_RUN;
        else if (wr_ctrl)
            run_r <= hwdata[`CTRL_RUN];
    end

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    wire step = tick & run_r;
    wire is_call = (rom_data[8:7] == `OP_CALL_HI);
    wire is_jump = (rom_data[8:7] == `OP_JUMP_HI);
    wire is_long = (rom_data[8:4] == `OP_LONG_HI);
    wire is_ret = (rom_data == `OP_RT) | (rom_data == `OP_RTS);
    wire is_rti = (rom_data == `OP_RTI);
    wire sense_low = ((rom_data == `OP_SENSE0) & !t_in[0]) | ((rom_data == `OP_SENSE1) & !t_in[1]);
    wire port_sel = ram_pointer_r.z;
    wire [7:0] pair_val = {acc_r.b, acc_r.a};
    wire [7:0] seg_val = seg_decode(acc_r.a);
    wire irq_take = irq_pend_r & irq_enable_flag_r;
    prog_counter_t pc_inc;
    prog_counter_t call_tgt;
    assign pc_inc = pc_next(pc_r);
    assign call_tgt = {4'h0, rom_data[6:0]};

    // interrupt request latch, a new edge wins over acceptance
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_prev_r <= 1'b0;
            irq_pend_r <= 1'b0;
        end
        else
        begin
            irq_prev_r <= irq_lvl;
            if (irq_lvl & !irq_prev_r)
                irq_pend_r <= 1'b1;
            else if (step && state_r == ST_EXEC && !skip_r && irq_take)
                irq_pend_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // sequencer and execution
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_EXEC;
            wait_r <= 2'h0;
            pc_r <= `RST_PC;
            stack_entry_first_r <= `RST_PC;
            stack_entry_second_r <= `RST_PC;
            sub_mode_flag_r <= 1'b0;
            sub_mode_save_r <= 1'b0;
            irq_enable_flag_r <= 1'b0;
            skip_r <= 1'b0;
            skip2_r <= 1'b0;
            call2_r <= 1'b0;
            long_page_r <= 4'h0;
            acc_r <= '0;
            ram_pointer_r <= '0;
            stage_r <= 8'h00;
            c_r <= 1'b0;
            out_r <= '0;
        end
        else
        begin
            // software loads of core registers; an instruction in the same cycle wins
            if (wr_acc)
                acc_r <= hwdata[8:0];
            if (wr_ptr)
                ram_pointer_r <= hwdata[6:0];
            if (step)
            begin
                unique case (state_r)
                    ST_EXEC:
                    begin
                        if (skip_r)
                        begin
                            // fetched and counted, but no effect
                            skip_r <= 1'b0;
                            pc_r <= pc_inc;
                            if (is_long)
                            begin
                                skip2_r <= 1'b1;
                                state_r <= ST_WORD2;
                            end
                        end
                        else if (irq_take)
                        begin
                            // vector in place of the word at pc, which runs after return
                            stack_entry_second_r <= stack_entry_first_r;
                            stack_entry_first_r <= pc_r;
                            sub_mode_save_r <= sub_mode_flag_r;
                            sub_mode_flag_r <= 1'b0;
                            irq_enable_flag_r <= 1'b0;
                            pc_r <= IRQ_VEC;
                            wait_r <= 2'(`CYC_CALL - 2'h1);
                            state_r <= ST_WAIT;
                        end
                        else if (is_call)
                        begin
                            if (!sub_mode_flag_r)
                            begin
                                stack_entry_second_r <= stack_entry_first_r;
                                stack_entry_first_r <= pc_inc;
                                sub_mode_flag_r <= 1'b1;
                            end
                            pc_r <= call_tgt;
                            wait_r <= 2'(`CYC_CALL - 2'h1);
                            state_r <= ST_WAIT;
                        end
                        else if (is_jump)
                        begin
                            // in-page jump, or page 1 while in subroutine mode
                            pc_r <= {sub_mode_flag_r ? 4'h1 : pc_r.page_field, rom_data[6:0]};
                            wait_r <= 2'(`CYC_CALL - 2'h1);
                            state_r <= ST_WAIT;
                        end
                        else if (is_long)
                        begin
                            long_page_r <= rom_data[3:0];
                            pc_r <= pc_inc;
                            state_r <= ST_WORD2;
                        end
                        else if (is_ret | is_rti)
                        begin
                            pc_r <= stack_entry_first_r;
                            stack_entry_first_r <= stack_entry_second_r;
                            sub_mode_flag_r <= is_rti ? sub_mode_save_r : 1'b0;
                            skip_r <= (rom_data == `OP_RTS);
                            wait_r <= 2'(`CYC_RET - 2'h1);
                            // interrupt return is a single cycle
                            state_r <= is_rti ? ST_EXEC : ST_WAIT;
                        end
                        else
                        begin
                            pc_r <= pc_inc;
                            if (rom_data == `OP_EI)
                                irq_enable_flag_r <= 1'b1;
                            if (rom_data == `OP_DI)
                                irq_enable_flag_r <= 1'b0;
                            if ((rom_data == `OP_SET_D) && port_sel)
                                out_r.d[ram_pointer_r.y] <= 1'b1;
                            if ((rom_data == `OP_RST_D) && port_sel)
                                out_r.d[ram_pointer_r.y] <= 1'b0;
                            if (rom_data == `OP_OUT_PAIR)
                            begin
                                stage_r <= pair_val;
                                out_r.s <= pair_val;
                                c_r <= acc_r.carry_flag;
                                out_r.p <= acc_r.carry_flag;
                            end
                            if (rom_data == `OP_OUT_SEG)
                            begin
                                stage_r <= seg_val;
                                out_r.s <= seg_val;
                                c_r <= acc_r.carry_flag;
                                out_r.p <= acc_r.carry_flag;
                            end
                            if (rom_data == `OP_OUT_STG)
                            begin
                                out_r.s <= stage_r;
                                out_r.p <= c_r;
                            end
                            if (rom_data == `OP_SHIFT)
                            begin
                                // top bit falls off
                                stage_r <= {stage_r[6:0], c_r};
                                c_r <= acc_r.carry_flag;
                            end
                            if (rom_data == `OP_IN_S)
                                acc_r.a <= s_low_in;
                            if (rom_data == `OP_IN_K)
                                acc_r.a <= k_in;
                            if (sense_low)
                                skip_r <= 1'b1;
                            if (rom_data == `OP_CLR_OUT)
                                out_r <= '0;
                        end
                    end
                    ST_WORD2:
                    begin
                        if (skip2_r)
                        begin
                            skip2_r <= 1'b0;
                            pc_r <= pc_inc;
                            state_r <= ST_EXEC;
                        end
                        else
                        begin
                            // bit 7 of the second word picks jump over call
                            if (!rom_data[7])
                            begin
                                stack_entry_second_r <= stack_entry_first_r;
                                stack_entry_first_r <= pc_inc;
                            end
                            call2_r <= !rom_data[7];
                            pc_r <= {long_page_r, rom_data[6:0]};
                            sub_mode_flag_r <= 1'b0;
                            wait_r <= 2'(`CYC_LONG - 2'h2);
                            state_r <= ST_WAIT;
                        end
                    end
                    ST_WAIT:
                    begin
                        // idle machine cycles of multi-cycle words
                        if (wait_r <= 2'h1)
                            state_r <= ST_EXEC;
                        wait_r <= wait_r - 2'h1;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rom_addr = pc_r;
    assign d_port = out_r.d;
    assign s_port_out = out_r.s;
    // a low latch bit releases the pin so the low nibble can be read
    assign s_port_oe_n = ~out_r.s;
    assign p_port = out_r.p;

endmodule // flow_port_core
`default_nettype wire

/* File: flow_port_defines.svh */
`ifndef FLOW_PORT_DEFINES_SVH
`define FLOW_PORT_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_ACC 8'h04
`define OFS_PTR 8'h08
`define OFS_STAT 8'h0C
`define OFS_PORT 8'h10

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_RUN 0
`define STAT_SM 11
`define STAT_IRQ_ENABLE_FLAG 12
`define STAT_SAVE 13
`define STAT_BUSY 14

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_RUN 1'b0
`define RST_PC 11'h000
`define RST_IRQ_VEC 11'h000

// ----------------------------------------
// opcodes (9-bit words)
// ----------------------------------------
`define OP_LONG_HI 5'h03
`define OP_CALL_HI 2'h2
`define OP_JUMP_HI 2'h3
`define OP_RT 9'h01F
`define OP_RTS 9'h01E
`define OP_RTI 9'h01D
`define OP_EI 9'h00B
`define OP_DI 9'h00A
`define OP_SET_D 9'h00F
`define OP_RST_D 9'h00E
`define OP_OUT_PAIR 9'h0B3
`define OP_OUT_SEG 9'h0B2
`define OP_OUT_STG 9'h0F2
`define OP_SHIFT 9'h008
`define OP_IN_S 9'h0F8
`define OP_IN_K 9'h0B8
`define OP_SENSE0 9'h001
`define OP_SENSE1 9'h004
`define OP_CLR_OUT 9'h007

// ----------------------------------------
// timing, in machine cycles and clocks
// ----------------------------------------
`define CYC_CALL 2'h2
`define CYC_RET 2'h2
`define CYC_LONG 2'h3
`define CYC_DIV_DEF 8'h04

`endif

/* File: flow_port_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------
// program store and s pin wiring
// ----------------
module flow_port_partner (
    input wire logic core_clk,
    input wire logic prog_we,
    input wire logic [10:0] prog_addr,
    input wire logic [8:0] prog_word,
    input wire flow_port_pkg::prog_counter_t rom_addr,
    output logic [8:0] rom_data,
    input wire logic [7:0] s_port_out,
    input wire logic [7:0] s_port_oe_n,
    input wire logic [3:0] ext_s,
    output logic [3:0] s_port_in
);
    import flow_port_pkg::*;
    logic [8:0] mem [2048]; // unwritten words act as no operation
    initial
    begin
        foreach (mem[i])
            mem[i] = 9'h000;
    end
    // loader port, written by the testbench before each test's reset, even while the core still runs
    always @(posedge core_clk)
    begin
        if (prog_we)
            mem[prog_addr] <= prog_word;
    end
    assign rom_data = mem[rom_addr];
    // open drain: a driven pin is high, an open one shows the outside
    assign s_port_in = (~s_port_oe_n[3:0] & s_port_out[3:0]) | (s_port_oe_n[3:0] & ext_s);
endmodule // flow_port_partner
`default_nettype wire

/* File: flow_port_pkg.sv */
// ----------------------------------------
// shared types
// ----------------------------------------
package flow_port_pkg;

    // sequencer phases
    typedef enum logic [1:0] {ST_EXEC, ST_WAIT, ST_WORD2} seq_state_t;

    // program counter: page and in-page address
    typedef struct packed {
        logic [3:0] page_field;
        logic [6:0] in_page_address;
    } prog_counter_t;

    // ram pointer: z, x, y concatenated
    typedef struct packed {
        logic z;
        logic [1:0] x;
        logic [3:0] y;
    } ram_pointer_t;

    // accumulator group
    typedef struct packed {
        logic carry_flag;
        logic [3:0] b;
        logic [3:0] a;
    } acc_regs_t;

    // output port latches
    typedef struct packed {
        logic p;
        logic [7:0] s;
        logic [15:0] d;
    } out_ports_t;

endpackage

/* File: mcu4_flow_and_port_instr_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mcu4_flow_and_port_instr_tb;
    import flow_port_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, p_port;
    logic [31:0] hrdata;
    prog_counter_t rom_addr;
    logic [8:0] rom_data;
    logic [15:0] d_port;
    logic [7:0] s_port_out, s_port_oe_n;
    logic [3:0] s_port_in;
    logic [3:0] k_port = 4'h9;
    logic [1:0] t_port = 2'h1; // sense0 high, sense1 low
    logic irq_in = 1'b0;
    logic prog_we = 1'b0;
    logic [10:0] prog_addr = 11'h0;
    logic [8:0] prog_word = 9'h0;
    logic [3:0] ext_s = 4'h4;
    int n_errors = 0;
    int num_checks = 0;
    always #25 core_clk = ~core_clk;
    // divider of one: every clock is a machine cycle
    flow_port_core #(.CYC_DIV(8'h01), .IRQ_VEC(11'h040)) DUT (.core_clk, .reset_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rom_addr, .rom_data,
        .d_port, .s_port_out, .s_port_oe_n, .s_port_in, .p_port, .k_port, .t_port, .irq_in);
    flow_port_partner u_far (.core_clk, .prog_we, .prog_addr, .prog_word, .rom_addr, .rom_data,
        .s_port_out, .s_port_oe_n, .ext_s, .s_port_in);
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_up(input int k);
        if (k >= 300)
        begin
            chk(32'h0, 32'h1);
            final_report();
        end
    endtask
    // wait for hready at a rising edge, bounded
    task automatic rdy;
        int k;
        k = 0;
        do
        begin
            @(posedge core_clk);
            k++;
        end
        while (hreadyout !== 1'b1 && k < 300);
        give_up(k);
    endtask
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r & m, e);
    endtask
    // poll a register until the masked value appears
    task automatic wt(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] r;
        int k;
        k = 0;
        do
        begin
            bus(1'b0, a, 32'h0, r);
            k++;
        end
        while ((r & m) !== e && k < 300);
        give_up(k);
    endtask
    task automatic go(input logic [10:0] halt);
        wr(8'h00, 32'h1);
        wt(8'h0C, 32'h7FF, {21'h0, halt});
    endtask
    task automatic ld(input logic [10:0] a, input logic [8:0] w);
        @(posedge core_clk);
        prog_we <= 1'b1;
        prog_addr <= a;
        prog_word <= w;
    endtask
    // eight words from base, first word in the top bits
    task automatic blk(input logic [10:0] base, input logic [71:0] w);
        for (int i = 0; i < 8; i++)
            ld(base + 11'(i), w[71 - 9 * i -: 9]);
    endtask
    task automatic rst;
        @(posedge core_clk);
        prog_we <= 1'b0;
        reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    task automatic t_ports(input logic z);
        blk(11'h000, {9'h00B, 9'h0B3, 9'h00F, 9'h007, 9'h00F, 9'h00A, 9'h186, 9'h000});
        rst();
        wr(8'h14, 32'hFFFF);
        rc(8'h14, 32'hFFFFFFFF, 32'h0);
        wr(8'h04, 32'h1FF);
        wr(8'h08, {25'h0, z, 6'h05});
        rc(8'h08, 32'h7F, {25'h0, z, 6'h05});
        go(11'h006);
        rc(8'h10, 32'h1FFFFFF, z ? 32'h20 : 32'h0);
        rc(8'h0C, 32'h1000, 32'h0);
        $display("ports test done");
    endtask
    task automatic t_io;
        blk(11'h000, {9'h0B3, 9'h0B8, 9'h008, 9'h0F2, 9'h000, 9'h000, 9'h0F8, 9'h187});
        rst();
        wr(8'h04, 32'h1A5);
        go(11'h007);
        rc(8'h10, 32'h1FFFFFF, 32'h014B0000);
        rc(8'h04, 32'h1FF, 32'h1AF);
        $display("staging test done");
    endtask
    task automatic t_flow;
        blk(11'h000, {9'h00F, 9'h110, 9'h00E, 9'h004, 9'h007, 9'h001, 9'h0B3, 9'h187});
        ld(11'h010, 9'h120);
        ld(11'h020, 9'h01E);
        rst();
        wr(8'h04, 32'h0C3);
        wr(8'h08, 32'h42);
        go(11'h007);
        rc(8'h10, 32'h1FFFFFF, 32'h00C30004);
        rc(8'h0C, 32'h800, 32'h0);
        $display("call test done");
    endtask
    task automatic t_long;
        blk(11'h000, {9'h00B, 9'h033, 9'h105, 9'h033, 9'h187, 9'h000, 9'h000, 9'h000});
        ld(11'h185, 9'h0B2);
        ld(11'h186, 9'h01F);
        ld(11'h187, 9'h187);
        rst();
        go(11'h187);
        rc(8'h0C, 32'h1800, 32'h1000);
        rc(8'h10, 32'h1FFFFFF, 32'h003F0000);
        $display("long test done");
    endtask
    task automatic t_irq;
        blk(11'h000, {9'h00B, 9'h102, 9'h102, 9'h000, 9'h000, 9'h000, 9'h000, 9'h000});
        ld(11'h040, 9'h00F);
        ld(11'h041, 9'h01D);
        rst();
        wr(8'h08, 32'h47);
        go(11'h002);
        irq_in <= 1'b1;
        wt(8'h10, 32'hFFFF, 32'h80);
        wt(8'h0C, 32'h7FF, 32'h2);
        rc(8'h0C, 32'h3800, 32'h2800);
        $display("interrupt test done");
    endtask
    initial
    begin
        rst();
        t_ports(1'b1);
        t_ports(1'b0);
        t_io();
        t_flow();
        t_long();
        t_irq();
        final_report();
    end
endmodule // mcu4_flow_and_port_instr_tb
`default_nettype wire
